// ---- logic/local_bus_cache_regs.vh ----
// constants for the local bus and secondary cache controller
// Notes on behaviour
// [RULE1] CPU cycle off cache and DRAM starts a local cycle with the strobe.
// [RULE2] CPU access touching both dwords runs two back-to-back local cycles.
// [RULE3] In non-CPU cycles the strobe is an input, watched for requests.
// [RULE4] Local target ends a CPU-launched local cycle with local ready.
// [RULE5] Device ends other masters' local memory requests with ready.
// [RULE6] Cycle-type lines are driven in CPU cycles, inputs otherwise.
// [RULE7] Local byte enables and address bit two come from CPU byte enables.
// [RULE8] Separate active-low output enables for even and odd 64-bit banks.
// [RULE9] Separate active-low write enables for even and odd 64-bit banks.
// [RULE10] On a cache read miss the line id RAM write enable is pulsed.
// [RULE11] Line id lines are inputs, driven only during its write enable.
// [RULE12] On a cache write hit the modified RAM write enable is pulsed.
// [RULE13] The modified input tells whether the addressed line was overwritten.
// [RULE14] Hit is line id match against upper address bits on a valid access.
// [RULE15] Dirty victim is written back before the fill and line id update.
`ifndef LOCAL_BUS_CACHE_REGS_VH
`define LOCAL_BUS_CACHE_REGS_VH
`define TAG_LSB      19
`define TAG_MSB      26
`define BANK_SEL_BIT 3
`define ST_IDLE      4'h0
`define ST_LB_STB    4'h1
`define ST_LB_WAIT   4'h2
`define ST_C_RD      4'h3
`define ST_C_WR      4'h4
`define ST_WB        4'h5
`define ST_FILL      4'h6
`define ST_TAGW      4'h7
`define ST_DWR       4'h8
`define ST_MS_WAIT   4'h9
`define ST_MS_RDY    4'hA
`endif

// ---- logic/lane_split.v ----
// maps the 8 cpu byte enables onto one 32-bit local bus half
`timescale 1ns/1ps
module lane_split (
    // cpu side
    input  wire [7:0] cpu_byte_en_n_in,
    input  wire       second_in,
    // local side
    output wire [3:0] lane_en_n_out,
    output wire       addr_bit2_out,
    output wire       two_cycles_out
);
    wire low_any;
    wire high_any;
    wire use_high;

    assign low_any  = ~&cpu_byte_en_n_in[3:0];
    assign high_any = ~&cpu_byte_en_n_in[7:4];
    // first cycle takes the low dword when it has any lane
    assign use_high       = second_in | ~low_any;                  // [RULE7]
    assign addr_bit2_out  = use_high;                              // [RULE7]
    assign lane_en_n_out  = use_high ? cpu_byte_en_n_in[7:4]
                                     : cpu_byte_en_n_in[3:0];      // [RULE7]
    assign two_cycles_out = low_any & high_any;                    // [RULE2]
endmodule // lane_split

// ---- logic/local_bus_cache_ctl.v ----
// local bus cycle control and secondary cache strobe control
`timescale 1ns/1ps
`include "local_bus_cache_regs.vh"
module local_bus_cache_ctl (
    // clock and reset
    input  wire        mclk_in,
    input  wire        rst_n_in,
    // cpu cycle
    input  wire        cpu_start_in,
    input  wire [31:3] cpu_addr_in,
    input  wire [7:0]  cpu_byte_en_n_in,
    input  wire        cpu_mem_or_io_in,
    input  wire        cpu_data_or_ctrl_in,
    input  wire        cpu_write_or_read_in,
    input  wire        local_mem_sel_in,
    input  wire        hold_ack_in,
    output wire        cpu_done_out,
    // dram controller
    output wire        dram_req_out,
    output wire        dram_wb_out,
    input  wire        dram_done_in,
    // other master's local memory access
    input  wire        mst_local_sel_in,
    output wire        mst_mem_req_out,
    input  wire        mst_mem_done_in,
    // local bus strobe and ready
    input  wire        local_addr_strobe_n_in,
    output wire        local_addr_strobe_n_out,
    output wire        local_addr_strobe_oe_n_out,
    input  wire        local_ready_n_in,
    output wire        local_ready_n_out,
    output wire        local_ready_oe_n_out,
    // local cycle type
    input  wire        local_mem_or_io_in,
    output wire        local_mem_or_io_out,
    input  wire        local_data_or_ctrl_in,
    output wire        local_data_or_ctrl_out,
    input  wire        local_write_or_read_in,
    output wire        local_write_or_read_out,
    input  wire [3:0]  local_byte_en_n_in,
    output wire [3:0]  local_byte_en_n_out,
    input  wire        local_addr_bit2_in,
    output wire        local_addr_bit2_out,
    output wire        local_type_oe_n_out,
    // cache strobes
    output wire        even_bank_out_en_n_out,
    output wire        odd_bank_out_en_n_out,
    output wire        even_bank_wr_en_n_out,
    output wire        odd_bank_wr_en_n_out,
    output wire        line_id_ram_wr_en_n_out,
    input  wire [7:0]  line_id_data_in,
    output wire [7:0]  line_id_data_out,
    output wire        line_id_data_oe_n_out,
    output wire        modified_ram_wr_en_n_out,
    input  wire        modified_in
);
    reg        rst_meta_r;
    reg        rst_sync_r;
    reg [3:0]  state_r;
    reg [3:0]  state_nxt;
    reg        second_r;
    reg        second_nxt;
    reg        bank_r;
    reg [7:0]  tag_r;
    reg        wr_r;
    reg        mio_r;
    reg        dc_r;
    reg [7:0]  be_n_r;
    reg        strobe_n_r;
    reg        done_r;
    reg        oe_n_r;
    reg        we_n_r;
    reg        tag_we_n_r;
    reg        dirty_we_n_r;
    reg        ready_n_r;
    wire [3:0] lane_n;
    wire       a2;
    wire       two;
    wire       tag_hit;
    wire       cpu_owns;
    wire       mst_req;

    // reset released through two flops
    always @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end

    lane_split lane_split_inst (
        .cpu_byte_en_n_in (be_n_r),
        .second_in        (second_r),
        .lane_en_n_out    (lane_n),
        .addr_bit2_out    (a2),
        .two_cycles_out   (two)
    );

    assign cpu_owns = ~hold_ack_in;
    // hit needs a started memory cycle in the dram range
    assign tag_hit = cpu_start_in & cpu_mem_or_io_in & local_mem_sel_in &
        (line_id_data_in == cpu_addr_in[`TAG_MSB:`TAG_LSB]);      // [RULE14]
    // foreign strobe is only looked at while another master owns the bus
    assign mst_req = hold_ack_in & ~local_addr_strobe_n_in &
                     local_mem_or_io_in & mst_local_sel_in;        // [RULE3]

    always @* begin
        state_nxt  = state_r;
        second_nxt = second_r;
        case (state_r)
            `ST_IDLE: begin
                second_nxt = 1'b0;
                if (mst_req) begin
                    state_nxt = `ST_MS_WAIT;                       // [RULE3]
                end else if (cpu_start_in & cpu_owns) begin
                    if (!(cpu_mem_or_io_in & local_mem_sel_in))
                        state_nxt = `ST_LB_STB;                    // [RULE1]
                    else if (tag_hit)
                        state_nxt = cpu_write_or_read_in ? `ST_C_WR
                                                         : `ST_C_RD;
                    else if (cpu_write_or_read_in)
                        state_nxt = `ST_DWR;
                    else if (modified_in)                  // [RULE13]
                        state_nxt = `ST_WB;                        // [RULE15]
                    else
                        state_nxt = `ST_FILL;
                end
            end
            `ST_LB_STB: begin
                state_nxt = `ST_LB_WAIT;
            end
            `ST_LB_WAIT: begin
                if (!local_ready_n_in) begin                       // [RULE4]
                    if (two & !second_r) begin
                        second_nxt = 1'b1;
                        state_nxt  = `ST_LB_STB;                   // [RULE2]
                    end else begin
                        state_nxt = `ST_IDLE;
                    end
                end
            end
            `ST_C_RD: begin
                state_nxt = `ST_IDLE;
            end
            `ST_C_WR: begin
                state_nxt = `ST_IDLE;
            end
            `ST_WB: begin
                if (dram_done_in)
                    state_nxt = `ST_FILL;                          // [RULE15]
            end
            `ST_FILL: begin
                if (dram_done_in)
                    state_nxt = `ST_TAGW;
            end
            `ST_TAGW: begin
                state_nxt = `ST_IDLE;
            end
            `ST_DWR: begin
                if (dram_done_in)
                    state_nxt = `ST_IDLE;
            end
            `ST_MS_WAIT: begin
                if (mst_mem_done_in)
                    state_nxt = `ST_MS_RDY;
            end
            `ST_MS_RDY: begin
                state_nxt = `ST_IDLE;
            end
            default: begin
                state_nxt = `ST_IDLE;
            end
        endcase
    end

    always @(posedge mclk_in or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            state_r      <= `ST_IDLE;
            second_r     <= 1'b0;
            bank_r       <= 1'b0;
            tag_r        <= 8'h00;
            wr_r         <= 1'b0;
            mio_r        <= 1'b0;
            dc_r         <= 1'b0;
            be_n_r       <= 8'hFF;
            strobe_n_r   <= 1'b1;
            done_r       <= 1'b0;
            oe_n_r       <= 1'b1;
            we_n_r       <= 1'b1;
            tag_we_n_r   <= 1'b1;
            dirty_we_n_r <= 1'b1;
            ready_n_r    <= 1'b1;
        end else begin
            state_r  <= state_nxt;
            second_r <= second_nxt;
            if (state_r == `ST_IDLE && cpu_start_in && cpu_owns) begin
                bank_r <= cpu_addr_in[`BANK_SEL_BIT];
                tag_r  <= cpu_addr_in[`TAG_MSB:`TAG_LSB];
                wr_r   <= cpu_write_or_read_in;
                mio_r  <= cpu_mem_or_io_in;
                dc_r   <= cpu_data_or_ctrl_in;
                be_n_r <= cpu_byte_en_n_in;
            end
            strobe_n_r   <= ~(state_nxt == `ST_LB_STB);             // [RULE1]
            // bank read on hit, and victim read out during write-back
            oe_n_r       <= ~(state_nxt == `ST_C_RD ||
                              state_nxt == `ST_WB);                 // [RULE8]
            we_n_r       <= ~(state_nxt == `ST_C_WR ||
                              state_nxt == `ST_TAGW);               // [RULE9]
            tag_we_n_r   <= ~(state_nxt == `ST_TAGW);               // [RULE10]
            dirty_we_n_r <= ~(state_nxt == `ST_C_WR);               // [RULE12]
            ready_n_r    <= ~(state_nxt == `ST_MS_RDY);             // [RULE5]
            done_r       <= (state_r != `ST_IDLE) &&
                            (state_r != `ST_MS_WAIT) &&
                            (state_r != `ST_MS_RDY) &&
                            (state_nxt == `ST_IDLE);
        end
    end

    assign cpu_done_out    = done_r;
    assign dram_req_out    = (state_r == `ST_WB) || (state_r == `ST_FILL) ||
                             (state_r == `ST_DWR);
    assign dram_wb_out     = (state_r == `ST_WB);
    assign mst_mem_req_out = (state_r == `ST_MS_WAIT);

    // strobe and type lines turn round with bus ownership
    assign local_addr_strobe_n_out    = strobe_n_r;
    assign local_addr_strobe_oe_n_out = ~cpu_owns;                 // [RULE3]
    assign local_mem_or_io_out        = mio_r;
    assign local_data_or_ctrl_out     = dc_r;
    assign local_write_or_read_out    = wr_r;
    assign local_byte_en_n_out        = lane_n;
    assign local_addr_bit2_out        = a2;
    assign local_type_oe_n_out        = ~cpu_owns;                 // [RULE6]
    // ready driven only once a foreign request was claimed
    assign local_ready_n_out    = ready_n_r;
    assign local_ready_oe_n_out = ~((state_r == `ST_MS_WAIT) ||
                                    (state_r == `ST_MS_RDY));      // [RULE5]

    assign even_bank_out_en_n_out   = oe_n_r | bank_r;             // [RULE8]
    assign odd_bank_out_en_n_out    = oe_n_r | ~bank_r;            // [RULE8]
    assign even_bank_wr_en_n_out    = we_n_r | bank_r;             // [RULE9]
    assign odd_bank_wr_en_n_out     = we_n_r | ~bank_r;            // [RULE9]
    assign line_id_ram_wr_en_n_out  = tag_we_n_r;
    assign line_id_data_out         = tag_r;
    assign line_id_data_oe_n_out    = tag_we_n_r;                  // [RULE11]
    assign modified_ram_wr_en_n_out = dirty_we_n_r;
endmodule // local_bus_cache_ctl

// ---- tb/local_bus_cache_ctl_properties.sv ----
// port checker for the local bus and cache strobe control
`timescale 1ns/1ps
module lbc_checker (
    input wire        mclk_in, rst_n_in, cpu_start_in, hold_ack_in,
    input wire [31:3] cpu_addr_in,
    input wire        cpu_mem_or_io_in, cpu_write_or_read_in,
    input wire        local_mem_sel_in, cpu_done_out, mst_mem_req_out,
    input wire        mst_mem_done_in, local_addr_strobe_n_out,
    input wire        local_addr_strobe_oe_n_out, local_type_oe_n_out,
    input wire        local_ready_n_out, local_ready_oe_n_out,
    input wire        even_bank_out_en_n_out, odd_bank_out_en_n_out,
    input wire        even_bank_wr_en_n_out, odd_bank_wr_en_n_out,
    input wire        line_id_ram_wr_en_n_out, line_id_data_oe_n_out,
    input wire        modified_ram_wr_en_n_out,
    input wire [7:0]  line_id_data_in
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);
    wire go  = cpu_start_in && !hold_ack_in;
    wire hit = go && cpu_mem_or_io_in && local_mem_sel_in
               && line_id_data_in == cpu_addr_in[26:19];
    a_strobe_on_miss: assert property (
        go && !(local_mem_sel_in && cpu_mem_or_io_in)
        |=> !local_addr_strobe_n_out) else $error("no strobe");
    a_strobe_single: assert property (
        $fell(local_addr_strobe_n_out) |=> local_addr_strobe_n_out)
        else $error("strobe too long");
    a_pins_turn: assert property (
        local_addr_strobe_oe_n_out == hold_ack_in
        && local_type_oe_n_out == hold_ack_in) else $error("pin turn");
    a_ready_ends: assert property (
        mst_mem_req_out && mst_mem_done_in |=> !local_ready_n_out
        && !local_ready_oe_n_out ##1 local_ready_n_out)
        else $error("ready wrong");
    a_hit_read: assert property (
        hit && !cpu_write_or_read_in && !cpu_addr_in[3]
        |=> !even_bank_out_en_n_out && odd_bank_out_en_n_out
        ##1 cpu_done_out && even_bank_out_en_n_out) else $error("hit rd");
    a_hit_write: assert property (
        hit && cpu_write_or_read_in && cpu_addr_in[3]
        |=> !odd_bank_wr_en_n_out && even_bank_wr_en_n_out
        && !modified_ram_wr_en_n_out ##1 cpu_done_out)
        else $error("hit wr");
    a_line_id_drive: assert property (
        line_id_data_oe_n_out == line_id_ram_wr_en_n_out)
        else $error("line id drive");
    a_line_id_pulse: assert property (
        $fell(line_id_ram_wr_en_n_out) |=> line_id_ram_wr_en_n_out)
        else $error("line id pulse");
    a_done_pulse: assert property (
        cpu_done_out |=> !cpu_done_out) else $error("done too long");
endmodule // lbc_checker
bind local_bus_cache_ctl lbc_checker lbc_checker_inst (.*);

// ---- tb/local_far_side.sv ----
// far side: local target, dram responder, line id and modified RAMs
`timescale 1ns/1ps
module local_far_side (
    input  wire       clk,
    input  wire       rst_n,
    input  wire [1:0] delay,
    input  wire       strobe_n,
    input  wire       dram_req,
    input  wire       tag_we_n,
    input  wire [7:0] tag_wd,
    input  wire       mod_we_n,
    output reg        ready_n,
    output reg        dram_done,
    output wire [7:0] tag_rd,
    output reg        dirty
);
    reg [7:0] tag_r;
    reg [1:0] lb_cnt, dr_cnt;
    reg       lb_busy;
    assign tag_rd = tag_we_n ? tag_r : tag_wd;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            {ready_n, dram_done, dirty, lb_busy} <= 4'h8;
            {tag_r, lb_cnt, dr_cnt} <= 12'h000;
        end else begin
            ready_n <= 1'b1;
            dram_done <= 1'b0;
            if (!strobe_n) begin
                lb_busy <= 1'b1;
                lb_cnt <= 2'h0;
            end else if (lb_busy && lb_cnt == delay) begin
                lb_busy <= 1'b0;
                ready_n <= 1'b0;
            end else if (lb_busy)
                lb_cnt <= lb_cnt + 2'h1;
            if (dram_req && !dram_done) begin
                dr_cnt <= (dr_cnt == delay) ? 2'h0 : dr_cnt + 2'h1;
                dram_done <= (dr_cnt == delay);
            end
            // a freshly filled line starts clean
            if (!tag_we_n) {tag_r, dirty} <= {tag_wd, 1'b0};
            if (!mod_we_n) dirty <= 1'b1;
        end
    end
endmodule // local_far_side

// ---- tb/tb_top.sv ----
// self-checking bench for the local bus and cache strobe control
`timescale 1ns/1ps
module tb_top;
    logic mclk_in = 0, rst_n_in = 0, cpu_start_in = 0, hold_ack_in = 0;
    logic [31:3] cpu_addr_in = 0;
    logic [7:0] cpu_byte_en_n_in = 8'hFF, exp_tag = 8'h00;
    logic cpu_mem_or_io_in = 1, cpu_data_or_ctrl_in = 1, exp_dirty = 0;
    logic cpu_write_or_read_in = 0, local_mem_sel_in = 0, mio_tb = 1;
    logic mst_local_sel_in = 0, mst_mem_done_in = 0, stb_tb = 1, rdy_far;
    logic cpu_done_out, dram_req_out, dram_wb_out, dram_done_in;
    logic mst_mem_req_out, local_addr_strobe_n_in, local_addr_strobe_n_out;
    logic local_addr_strobe_oe_n_out, local_ready_n_in, local_ready_n_out;
    logic local_ready_oe_n_out, local_mem_or_io_in, local_mem_or_io_out;
    logic local_data_or_ctrl_in, local_data_or_ctrl_out, local_type_oe_n_out;
    logic local_write_or_read_in, local_write_or_read_out, wr_seen;
    logic mio_seen, dc_seen, bank_tb = 0;
    int n_bwe, n_boe, n_wrong;
    logic [3:0] local_byte_en_n_in, local_byte_en_n_out, be_first, be_last;
    logic local_addr_bit2_in, local_addr_bit2_out, b2_first, b2_last;
    logic even_bank_out_en_n_out, odd_bank_out_en_n_out, line_id_data_oe_n_out;
    logic even_bank_wr_en_n_out, odd_bank_wr_en_n_out, line_id_ram_wr_en_n_out;
    logic [7:0] line_id_data_in, line_id_data_out, tag_seen;
    logic modified_ram_wr_en_n_out, modified_in;
    logic [1:0] dly = 0;
    logic [7:0] corner [4] = '{8'h00, 8'hF0, 8'h0F, 8'h7E};
    int err_count = 0, samples_checked = 0, n_stb, n_tag, n_mod, n_wb, n_rdy;
    // each shared pin resolves to whoever has it enabled
    assign local_addr_strobe_n_in = local_addr_strobe_oe_n_out ? stb_tb
                                    : local_addr_strobe_n_out;
    assign local_ready_n_in = local_ready_oe_n_out ? rdy_far
                              : local_ready_n_out;
    assign local_mem_or_io_in = local_type_oe_n_out ? mio_tb
                                : local_mem_or_io_out;
    assign local_data_or_ctrl_in = local_type_oe_n_out
                                   | local_data_or_ctrl_out;
    assign local_write_or_read_in = !local_type_oe_n_out
                                    & local_write_or_read_out;
    assign local_byte_en_n_in = local_type_oe_n_out ? 4'h0
                                : local_byte_en_n_out;
    assign local_addr_bit2_in = !local_type_oe_n_out & local_addr_bit2_out;
    local_bus_cache_ctl local_bus_cache_ctl_inst (.*);
    local_far_side local_far_side_inst (.clk(mclk_in), .rst_n(rst_n_in),
        .delay(dly), .strobe_n(local_addr_strobe_n_out
        | local_addr_strobe_oe_n_out), .dram_req(dram_req_out),
        .tag_we_n(line_id_ram_wr_en_n_out), .tag_wd(line_id_data_out),
        .mod_we_n(modified_ram_wr_en_n_out), .ready_n(rdy_far),
        .dram_done(dram_done_in), .tag_rd(line_id_data_in),
        .dirty(modified_in));
    always #25 mclk_in = ~mclk_in;
    // sampled mid-cycle, clear of the edge that launches the outputs
    always @(negedge mclk_in) begin
        if (!local_addr_strobe_n_out && !local_addr_strobe_oe_n_out) begin
            if (n_stb == 0) {b2_first, be_first} = {local_addr_bit2_out,
                                                    local_byte_en_n_out};
            {b2_last, be_last} = {local_addr_bit2_out, local_byte_en_n_out};
            {wr_seen, mio_seen, dc_seen} = {local_write_or_read_out,
                local_mem_or_io_out, local_data_or_ctrl_out};
            n_stb++;
        end
        if (bank_tb ? !odd_bank_wr_en_n_out : !even_bank_wr_en_n_out)
            n_bwe++;
        if (bank_tb ? !odd_bank_out_en_n_out : !even_bank_out_en_n_out)
            n_boe++;
        if (bank_tb ? !(even_bank_wr_en_n_out & even_bank_out_en_n_out)
                    : !(odd_bank_wr_en_n_out & odd_bank_out_en_n_out))
            n_wrong++;
        if (!line_id_ram_wr_en_n_out) {n_tag, tag_seen} = {n_tag + 1,
                                                           line_id_data_out};
        if (!modified_ram_wr_en_n_out) n_mod++;
        if (dram_req_out && dram_wb_out && n_tag == 0) n_wb++;
        if (!local_ready_n_out && !local_ready_oe_n_out) n_rdy++;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic finish_test;
        if (err_count == 0 && samples_checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic cpu_op(input logic [7:0] tg, input logic [7:0] be,
                          input logic bk, w, ls, mem);
        logic lo, two, loc, miss, hr, rm;
        logic [3:0] fe;
        int k;
        lo = be[3:0] != 4'hF;
        two = lo && be[7:4] != 4'hF;
        fe = lo ? be[3:0] : be[7:4];
        loc = ls && mem;
        miss = loc && tg != exp_tag;
        hr = loc && !miss && !w;
        rm = miss && !w;
        {n_stb, n_tag, n_mod, n_wb, n_bwe, n_boe, n_wrong} = 0;
        bank_tb = bk;
        cpu_addr_in = {5'h00, tg, 15'($urandom), bk};
        cpu_data_or_ctrl_in = 1'($urandom);
        {cpu_byte_en_n_in, cpu_write_or_read_in} = {be, w};
        {local_mem_sel_in, cpu_mem_or_io_in, cpu_start_in} = {ls, mem, 1'b1};
        dly = 2'($urandom_range(3));
        @(negedge mclk_in) cpu_start_in = 0;
        for (k = 0; k < 60 && cpu_done_out !== 1'b1; k++) @(negedge mclk_in);
        if (cpu_done_out !== 1'b1) begin
            err_count++;
            finish_test;
        end
        @(negedge mclk_in);
        check(n_stb, loc ? 0 : (two ? 2 : 1));
        if (!loc) begin
            check({b2_first, be_first}, {!lo, fe});
            check({b2_last, be_last}, {!lo | two, two ? be[7:4] : fe});
            check(wr_seen, w);
            check(mio_seen, mem);
            check(dc_seen, cpu_data_or_ctrl_in);
        end
        check(n_wrong, 0);
        check(n_bwe, (loc && !miss && w) || rm);
        check(n_boe > 0, hr || (rm && exp_dirty));
        check(n_tag, miss && !w);
        if (miss && !w) check(tag_seen, tg);
        check(n_mod, loc && !miss && w);
        check(n_wb > 0, miss && !w && exp_dirty);
        if (miss && !w) {exp_tag, exp_dirty} = {tg, 1'b0};
        if (loc && !miss && w) exp_dirty = 1;
    endtask
    task automatic foreign(input logic sel);
        int k;
        {n_rdy, hold_ack_in, mst_local_sel_in} = {32'h0, 1'b1, sel};
        @(negedge mclk_in) stb_tb = 0;
        @(negedge mclk_in) stb_tb = 1;
        for (k = 0; k < 5 && mst_mem_req_out !== 1'b1; k++) @(negedge mclk_in);
        check(mst_mem_req_out, sel);
        repeat ($urandom_range(3)) @(negedge mclk_in);
        mst_mem_done_in = sel;
        @(negedge mclk_in) mst_mem_done_in = 0;
        repeat (3) @(negedge mclk_in);
        check(n_rdy, sel);
        check(local_ready_oe_n_out, 1'b1);
        {hold_ack_in, mst_local_sel_in} = 0;
    endtask
    initial begin
        void'($urandom(52253));
        repeat (6) @(negedge mclk_in);
        rst_n_in = 1;
        repeat (3) @(negedge mclk_in);
        for (int i = 0; i < 4; i++)
            cpu_op(8'h11, corner[i], 0, i[0], i[1], !i[1]);
        cpu_op(8'h11, 8'h00, 0, 0, 1, 1);
        cpu_op(8'h11, 8'h00, 1, 1, 1, 1);
        cpu_op(8'h11, 8'h0F, 0, 0, 1, 1);
        cpu_op(8'h22, 8'h00, 0, 1, 1, 1);
        cpu_op(8'h22, 8'hF0, 0, 0, 1, 1);
        foreign(1);
        foreign(0);
        repeat (60) cpu_op($urandom_range(1) ? 8'h11 : 8'h22,
            8'($urandom_range(254)), 1'($urandom), 1'($urandom),
            $urandom_range(3) != 0, $urandom_range(7) != 0);
        foreign(1);
        finish_test;
    end
endmodule // tb_top
